// >>> design/ldsc_pkg.sv
/*
 * Shared constants and types of the LED drive sequence configuration block:
 * register offsets, reset values, slot codes, current steps and port structs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ldsc_pkg;

   localparam logic [7:0] OFS_DRV1_AMP   = 8'h0C;
   localparam logic [7:0] OFS_DRV2_AMP   = 8'h0D;
   localparam logic [7:0] OFS_DRV3_AMP   = 8'h0E;
   localparam logic [7:0] OFS_DRV4_AMP   = 8'h0F;
   localparam logic [7:0] OFS_RANGES     = 8'h11;
   localparam logic [7:0] OFS_PILOT_AMP  = 8'h12;
   localparam logic [7:0] OFS_SEQ_12     = 8'h13;
   localparam logic [7:0] OFS_SEQ_34     = 8'h14;
   localparam logic [7:0] OFS_XTALK_CH1  = 8'h26;
   localparam logic [7:0] OFS_XTALK_CH2  = 8'h27;
   localparam logic [7:0] OFS_XTALK_CH3  = 8'h28;
   localparam logic [7:0] OFS_XTALK_CH4  = 8'h29;

   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [4:0] RST_XTALK      = 5'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;
   localparam logic [2:0] XTALK_PAD      = 3'h0;

   localparam logic [1:0] MODE_FLEX      = 2'h3;

   // slot codes
   localparam logic [3:0] SLOT_OFF       = 4'h0;
   localparam logic [3:0] SLOT_DRV_FIRST = 4'h1;
   localparam logic [3:0] SLOT_DRV_LAST  = 4'h4;
   localparam logic [3:0] SLOT_PIL_FIRST = 4'h5;
   localparam logic [3:0] SLOT_PIL_LAST  = 4'h8;
   localparam logic [1:0] SLOT_IDX_LAST  = 2'h3;

   // current steps
   localparam int unsigned AMP_STEP_UA      = 200;  // 0.2 mA per code at range 0
   localparam int unsigned XTALK_STEP_NA    = 64;   // per code at converter range 0
   localparam int unsigned FULL_SCALE_MA_0  = 50;   // range 0 full scale

   typedef enum logic [1:0] {
      LDSC_IDLE = 2'b00,
      LDSC_SLOT = 2'b01,
      LDSC_DONE = 2'b10
   } ldsc_seq_e;

   // one register port access
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } ldsc_regreq_s;

   // what the analog side sees for the active slot
   typedef struct packed {
      logic        active;
      logic [3:0]  fireOneHot;
      logic [3:0]  elemType;
      logic [1:0]  slotIdx;
      logic [7:0]  amplitude;
      logic [1:0]  currentRange;
      logic [17:0] driveCurrentUa;
      logic [13:0] cancelCurrentNa;
   } ldsc_drive_s;

endpackage

// >>> design/ldsc_slot_decode.sv
/*
 * Decodes one four-bit sequence slot code into driver index, on flag and
 * pilot flag. Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none
module ldsc_slot_decode
   import ldsc_pkg::*;
(
   input  wire logic [3:0] slotCode,
   output logic            slotOn,
   output logic            slotPilot,
   output logic [1:0]      drvIdx
);
   always_comb begin
      slotOn    = 1'b0;
      slotPilot = 1'b0;
      drvIdx    = 2'h0;
      if (slotCode >= SLOT_DRV_FIRST && slotCode <= SLOT_DRV_LAST) begin
         slotOn = 1'b1;
         drvIdx = 2'(slotCode - SLOT_DRV_FIRST);
      end else if (slotCode >= SLOT_PIL_FIRST && slotCode <= SLOT_PIL_LAST) begin
         slotOn    = 1'b1;
         slotPilot = 1'b1;
         drvIdx    = 2'(slotCode - SLOT_PIL_FIRST);
      end
      // off and reserved codes leave everything low
   end
endmodule
`default_nettype wire

// >>> design/ldsc_top.sv
/*
 * LED drive sequence configuration: amplitude, range, pilot, slot sequence
 * and crosstalk code registers behind a byte-wide register port, plus the
 * slot walker that presents one firing slot at a time in flexible mode.
 * Assumes the host interface delivers one-cycle register strobes and that
 * mode, converter range and the sample/conversion pulses come from outside.
 */
`timescale 1ns/1ps
`default_nettype none
module ldsc_top
   import ldsc_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire ldsc_pkg::ldsc_regreq_s regReq,
   output logic [7:0]                 regRdData,
   output logic                       regRdValid,
   input  wire logic [1:0]            operatingMode,
   input  wire logic [1:0]            converterRange,
   input  wire logic                  sampleStart,
   input  wire logic                  convStep,
   output ldsc_pkg::ldsc_drive_s      drive,
   output logic                       elemStart,
   output logic                       sampleDone
);
   import ldsc_pkg::*;

   typedef struct packed {
      logic [3:0][7:0] drvAmplitude;
      logic [7:0]      currentRanges;
      logic [7:0]      sharedLowAmplitude;
      logic [7:0]      seqSlotsOneTwo;
      logic [7:0]      seqSlotsThreeFour;
      logic [3:0][4:0] cancelCode;
      logic [7:0]      rdData;
      logic            rdValid;
      ldsc_seq_e       seq;
      logic [1:0]      slotIdx;
      ldsc_drive_s     drive;
      logic            elemStart;
      logic            sampleDone;
   } ldsc_state_s;

   ldsc_state_s st_r;
   ldsc_state_s st_nxt;

   logic [3:0] curCode;
   logic       curOn;
   logic       curPilot;
   logic [1:0] curDrv;

   // amplitude code times 0.2 mA times (range + 1), in microamps
   function automatic logic [17:0] drive_ua(input logic [7:0] amp, input logic [1:0] rng);
      logic [17:0] stepUa;
      stepUa = 18'(AMP_STEP_UA) * (18'(rng) + 18'h1);
      return 18'(18'(amp) * stepUa);
   endfunction

   // cancel code times 64 nA doubled per converter range step, in nanoamps
   function automatic logic [13:0] cancel_na(input logic [4:0] code, input logic [1:0] rng);
      logic [13:0] stepNa;
      stepNa = 14'(14'(XTALK_STEP_NA) << rng);
      return 14'(14'(code) * stepNa);
   endfunction

   function automatic logic [3:0] slot_code(input logic [7:0] s12, input logic [7:0] s34,
                                            input logic [1:0] idx);
      logic [3:0] c;
      case (idx)
         2'h0:    c = s12[3:0];
         2'h1:    c = s12[7:4];
         2'h2:    c = s34[3:0];
         default: c = s34[7:4];
      endcase
      return c;
   endfunction

   assign curCode = slot_code(st_r.seqSlotsOneTwo, st_r.seqSlotsThreeFour, st_r.slotIdx);

   ldsc_slot_decode u_decode (
      .slotCode  (curCode),
      .slotOn    (curOn),
      .slotPilot (curPilot),
      .drvIdx    (curDrv)
   );

   always_comb begin
      logic [1:0] rng;
      logic [7:0] amp;
      logic       advance;
      rng     = 2'h0;
      amp     = 8'h00;
      advance = 1'b0;
      st_nxt  = st_r;
      st_nxt.rdValid    = 1'b0;
      st_nxt.elemStart  = 1'b0;
      st_nxt.sampleDone = 1'b0;

      // register port writes
      if (regReq.wrEn) begin
         case (regReq.addr)
            OFS_DRV1_AMP:  st_nxt.drvAmplitude[0] = regReq.wrData;
            OFS_DRV2_AMP:  st_nxt.drvAmplitude[1] = regReq.wrData;
            OFS_DRV3_AMP:  st_nxt.drvAmplitude[2] = regReq.wrData;
            OFS_DRV4_AMP:  st_nxt.drvAmplitude[3] = regReq.wrData;
            OFS_RANGES:    st_nxt.currentRanges = regReq.wrData;
            OFS_PILOT_AMP: st_nxt.sharedLowAmplitude = regReq.wrData;
            OFS_SEQ_12:    st_nxt.seqSlotsOneTwo = regReq.wrData;
            OFS_SEQ_34:    st_nxt.seqSlotsThreeFour = regReq.wrData;
            OFS_XTALK_CH1: st_nxt.cancelCode[0] = regReq.wrData[4:0];
            OFS_XTALK_CH2: st_nxt.cancelCode[1] = regReq.wrData[4:0];
            OFS_XTALK_CH3: st_nxt.cancelCode[2] = regReq.wrData[4:0];
            OFS_XTALK_CH4: st_nxt.cancelCode[3] = regReq.wrData[4:0];
            default: ;
         endcase
      end

      // register port reads, one cycle later; a same-cycle write is not seen
      if (regReq.rdEn) begin
         st_nxt.rdValid = 1'b1;
         case (regReq.addr)
            OFS_DRV1_AMP:  st_nxt.rdData = st_r.drvAmplitude[0];
            OFS_DRV2_AMP:  st_nxt.rdData = st_r.drvAmplitude[1];
            OFS_DRV3_AMP:  st_nxt.rdData = st_r.drvAmplitude[2];
            OFS_DRV4_AMP:  st_nxt.rdData = st_r.drvAmplitude[3];
            OFS_RANGES:    st_nxt.rdData = st_r.currentRanges;
            OFS_PILOT_AMP: st_nxt.rdData = st_r.sharedLowAmplitude;
            OFS_SEQ_12:    st_nxt.rdData = st_r.seqSlotsOneTwo;
            OFS_SEQ_34:    st_nxt.rdData = st_r.seqSlotsThreeFour;
            OFS_XTALK_CH1: st_nxt.rdData = {XTALK_PAD, st_r.cancelCode[0]};
            OFS_XTALK_CH2: st_nxt.rdData = {XTALK_PAD, st_r.cancelCode[1]};
            OFS_XTALK_CH3: st_nxt.rdData = {XTALK_PAD, st_r.cancelCode[2]};
            OFS_XTALK_CH4: st_nxt.rdData = {XTALK_PAD, st_r.cancelCode[3]};
            default:       st_nxt.rdData = UNMAPPED_READ;
         endcase
      end

      // the pilot being lower than normal amplitudes is software's job
      rng = st_r.currentRanges[2*curDrv +: 2];
      amp = curPilot ? st_r.sharedLowAmplitude : st_r.drvAmplitude[curDrv];

      case (st_r.seq)
         LDSC_IDLE: begin
            st_nxt.drive.active = 1'b0;
            if (sampleStart && operatingMode == MODE_FLEX) begin
               st_nxt.seq     = LDSC_SLOT;
               st_nxt.slotIdx = 2'h0;
            end
         end
         LDSC_SLOT: begin
            if (operatingMode != MODE_FLEX) begin
               // leaving flex mode aborts the sample at once
               st_nxt.seq          = LDSC_IDLE;
               st_nxt.drive.active = 1'b0;
            end else if (!curOn) begin
               // off slots cost no conversion, so they are skipped in one cycle
               st_nxt.drive.active = 1'b0;
               advance = 1'b1;
            end else if (!st_r.drive.active) begin
               st_nxt.drive.active          = 1'b1;
               st_nxt.elemStart             = 1'b1;
               st_nxt.drive.slotIdx         = st_r.slotIdx;
               st_nxt.drive.elemType        = curCode;
               st_nxt.drive.fireOneHot      = 4'(4'h1 << curDrv);
               st_nxt.drive.amplitude       = amp;
               st_nxt.drive.currentRange    = rng;
               st_nxt.drive.driveCurrentUa  = drive_ua(amp, rng);
               // zero code gives zero current, i.e. no subtraction
               st_nxt.drive.cancelCurrentNa = cancel_na(st_r.cancelCode[curDrv], converterRange);
            end else if (convStep) begin
               st_nxt.drive.active = 1'b0;
               advance = 1'b1;
            end
            if (advance) begin
               if (st_r.slotIdx == SLOT_IDX_LAST) begin
                  st_nxt.seq = LDSC_DONE;
               end else begin
                  st_nxt.slotIdx = st_r.slotIdx + 2'h1;
               end
            end
         end
         LDSC_DONE: begin
            st_nxt.sampleDone = 1'b1;
            st_nxt.seq        = LDSC_IDLE;
         end
         default: begin
            st_nxt.seq          = LDSC_IDLE;
            st_nxt.drive.active = 1'b0;
         end
      endcase
      if (!st_nxt.drive.active) begin
         st_nxt.drive.fireOneHot = 4'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.seq <= LDSC_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdData  = st_r.rdData;
   assign regRdValid = st_r.rdValid;
   assign drive      = st_r.drive;
   assign elemStart  = st_r.elemStart;
   assign sampleDone = st_r.sampleDone;

   // full scale at code 0xFA is FULL_SCALE_MA_0 times (range + 1) mA
   localparam int unsigned FULL_SCALE_REF = FULL_SCALE_MA_0;
endmodule
`default_nettype wire

// >>> verif/ldsc_top_chk.sv
/* Assertions on the ports of the LED drive sequence configuration block.
   Assumes ldsc_pkg is compiled first; bound to every ldsc_top below. */
`timescale 1ns/1ps
`default_nettype none
module ldsc_top_chk
   import ldsc_pkg::*;
(
   input wire logic                   ref_clk,
   input wire logic                   rstn,
   input wire ldsc_pkg::ldsc_regreq_s regReq,
   input wire logic [7:0]             regRdData,
   input wire logic                   regRdValid,
   input wire logic [1:0]             operatingMode,
   input wire logic [1:0]             converterRange,
   input wire logic                   sampleStart,
   input wire logic                   convStep,
   input wire ldsc_pkg::ldsc_drive_s  drive,
   input wire logic                   elemStart,
   input wire logic                   sampleDone
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [13:0] stepNa;
   // bench keeps the converter range still during a walk, so live value is fair
   assign stepNa = 14'(XTALK_STEP_NA << converterRange);
   a_read_answer: assert property (regReq.rdEn |=> regRdValid)
      else $error("read strobe not answered next cycle");
   a_valid_cause: assert property (regRdValid |-> $past(regReq.rdEn))
      else $error("read valid without a read");
   a_cancel_pad: assert property (regRdValid && $past(regReq.addr) inside {[OFS_XTALK_CH1:OFS_XTALK_CH4]}
      |-> regRdData[7:5] == XTALK_PAD) else $error("cancel code upper bits not zero");
   a_elem_rise: assert property (elemStart |-> drive.active && !$past(drive.active))
      else $error("element start not at slot start");
   a_idle_dark: assert property (!drive.active |-> drive.fireOneHot == 4'h0)
      else $error("driver fired outside an active slot");
   a_fire_match: assert property (drive.active |-> drive.elemType inside {[4'h1:4'h8]} &&
      drive.fireOneHot == 4'h1 << ((drive.elemType - 4'h1) & 4'h3)) else $error("fired driver differs from slot code");
   a_drive_calc: assert property (drive.active |->
      drive.driveCurrentUa == 18'(drive.amplitude * AMP_STEP_UA * (drive.currentRange + 18'h1)))
      else $error("drive current not amplitude times step");
   a_cancel_step: assert property (drive.active |-> drive.cancelCurrentNa <= 14'h1F * stepNa &&
      drive.cancelCurrentNa % stepNa == 14'h0) else $error("cancel current off the step grid");
   a_active_hold: assert property (drive.active && !convStep && operatingMode == MODE_FLEX |=> drive.active)
      else $error("slot ended without conversion");
   a_active_drop: assert property (drive.active && convStep |=> !drive.active)
      else $error("slot kept after conversion");
   a_mode_gate: assert property ((operatingMode != MODE_FLEX) [*2] |-> !drive.active)
      else $error("slot active outside flexible mode");
   c_pilot: cover property (elemStart && drive.elemType == SLOT_PIL_LAST);
   c_zero_cancel: cover property (drive.active && drive.cancelCurrentNa == 14'h0);
   c_done: cover property (sampleDone);
endmodule
bind ldsc_top ldsc_top_chk u_chk (.ref_clk, .rstn, .regReq, .regRdData, .regRdValid, .operatingMode,
   .converterRange, .sampleStart, .convStep, .drive, .elemStart, .sampleDone);
`default_nettype wire

// >>> verif/ldsc_top_tb_top.sv
/* Self-checking bench of the LED drive sequence configuration block.
   Drives the register port and the walk pulses itself; no partner model. */
`timescale 1ns/1ps
`default_nettype none
module ldsc_top_tb_top;
   import ldsc_pkg::*;
   logic         ref_clk = 1'b0;
   logic         rstn = 1'b0;
   ldsc_regreq_s regReq = '0;
   logic [7:0]   regRdData;
   logic         regRdValid;
   logic [1:0]   operatingMode = MODE_FLEX;
   logic [1:0]   converterRange = 2'h0;
   logic         sampleStart = 1'b0;
   logic         convStep = 1'b0;
   ldsc_drive_s  drive;
   logic         elemStart;
   logic         sampleDone;
   int           errorCnt = 0;
   int           checkCount = 0;
   logic [7:0]   ofs [12] = '{OFS_DRV1_AMP, OFS_DRV2_AMP, OFS_DRV3_AMP, OFS_DRV4_AMP, OFS_RANGES, OFS_PILOT_AMP,
                              OFS_SEQ_12, OFS_SEQ_34, OFS_XTALK_CH1, OFS_XTALK_CH2, OFS_XTALK_CH3, OFS_XTALK_CH4};
   // pilot kept below every own amplitude; driver n gets range n-1
   logic [7:0]   val [12] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'hE4, 8'h08, 8'h61, 8'h49, 8'hE3, 8'h00, 8'h05, 8'h1F};
   always #5 ref_clk = ~ref_clk;
   ldsc_top DUT (.ref_clk, .rstn, .regReq, .regRdData, .regRdValid, .operatingMode, .converterRange,
      .sampleStart, .convStep, .drive, .elemStart, .sampleDone);
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      regReq <= '0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      regReq <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk);
      regReq <= '0;
      // answer stands for the one cycle after the strobe edge
      #1;
      chk("read data", {e, 1'b1}, {regRdData, regRdValid});
      @(posedge ref_clk);
   endtask
   // walk k: slot one own driver k+1, slot two pilot on it, slot three reserved, four off
   task automatic walk(input int k);
      logic [7:0]  a;
      logic [63:0] exp;
      wr(OFS_SEQ_12, {4'(k + 5), 4'(k + 1)});
      wr(OFS_SEQ_34, {SLOT_OFF, 4'(k + 9)});
      converterRange <= 2'(k);
      sampleStart <= 1'b1;
      @(posedge ref_clk);
      sampleStart <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         a = (s == 1) ? val[5] : val[k];
         exp = {10'h0, 2'b11, 4'h1 << k, 4'(k + 1 + 4 * s), 2'(s), a, 2'(k), 18'(a * AMP_STEP_UA * (k + 1)),
                14'(val[8 + k][4:0] * (XTALK_STEP_NA << k))};
         // step off the edge so the previous slot's drive is not mistaken for this one
         #1;
         repeat (20) if (drive.active !== 1'b1) begin
            @(posedge ref_clk);
            #1;
         end
         chk("slot drive", exp, {elemStart, drive});
         @(posedge ref_clk);
         convStep <= 1'b1;
         @(posedge ref_clk);
         convStep <= 1'b0;
      end
      repeat (30) if (sampleDone !== 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      chk("sample done", 1, sampleDone);
      @(posedge ref_clk);
   endtask
   task automatic closeOut;
      $display("checks %0d mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      foreach (ofs[i]) rd(ofs[i], RST_BYTE);
      foreach (ofs[i]) wr(ofs[i], val[i]);
      foreach (ofs[i]) rd(ofs[i], (i >= 8) ? {XTALK_PAD, val[i][4:0]} : val[i]);
      wr(8'h10, 8'hFF);
      rd(8'h10, UNMAPPED_READ);
      for (int k = 0; k < 4; k++) walk(k);
      // leaving flex mode in mid-walk must drop the slot without a done pulse
      sampleStart <= 1'b1;
      @(posedge ref_clk);
      sampleStart <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("walk start", 1, drive.active);
      @(posedge ref_clk);
      operatingMode <= 2'h2;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("walk abort", 0, {drive.active, sampleDone});
      operatingMode <= 2'h2;
      sampleStart <= 1'b1;
      @(posedge ref_clk);
      sampleStart <= 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      chk("walk outside flex mode", 0, {drive.active, elemStart});
      closeOut;
   end
   // a normal run is under two microseconds; more than twenty-five times that means a hang
   initial begin
      #50us;
      errorCnt++;
      closeOut;
   end
endmodule
`default_nettype wire
